// ===== cis_unit.sv
// Purpose: executes the and..port-input instruction slice under APB control
// Assumes: mem_ack is a one-cycle pulse; mem_rdata right aligned
// Notes:   zero-wait APB slave, writes refused while busy or asleep
// Function
// - register and: reg2 = reg1 & reg2, excess cleared, sign/zero set, carry kept
// - immediate and: zero-extended imm16 & reg1 into reg2, clear excess/sign
// - conditional jumps add displacement only when condition holds, flags kept
// - always jump adds displacement to pc unconditionally, flags kept
// - data ram fill: four words external (reg1) into data ram (reg2)
// - data ram dump: four words data ram (reg2) out to external (reg1)
// - instr ram fill: four words external (reg1) into instruction ram
// - instr ram dump: four words instruction ram out to external memory
// - fatal return leaves fatal handling, resumes saved pc, flags kept
// - interlock exchange at reg1 plus displacement, updates all four flags
// - register compare: reg2 minus reg1, result dropped, four flags set
// - immediate compare: reg2 minus sign-extended imm5, four flags set
// - irq off blocks maskable interrupts, nmi unaffected
// - irq on permits maskable interrupts, nmi never gated
// - signed divide: quotient to reg2, remainder register takes dividend sign
// - unsigned divide: quotient reg2, remainder register, excess cleared, carry kept
// - halt stops execution and enters sleep
// - byte port input at reg1 plus sign-extended disp16, zero-extended
// - halfword port input forces address bit 0 low, zero-extended
// - word port input forces address bits 1:0 low, stored unchanged
// - jump displacement is nine bits with bit 0 taken as zero
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module cis_unit (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	output cis_pkg::cis_mem_req_t      mem_req,
	input  wire logic                  mem_ack,
	input  wire logic [31:0]           mem_rdata,
	input  wire logic                  int_req,
	input  wire logic                  nmi_req,
	output logic                       irq_take,
	output logic                       nmi_take,
	output logic                       sleeping
);
	import cis_pkg::*;

	logic [31:0]  opa_ff;
	logic [31:0]  opb_ff;
	logic [31:0]  imm_ff;
	logic [31:0]  pc_ff;
	logic [31:0]  fepc_ff;
	logic [31:0]  remainder_register_ff;
	logic [3:0]   flags_ff;
	logic         ie_ff;
	logic         sleep_ff;
	logic         fatal_ff;
	cis_state_t   state_ff;
	cis_op_t      op_ff;
	logic [1:0]   beat_ff;
	cis_mem_req_t mem_ff;
	logic [31:0]  prdata_ff;
	logic         pready_ff;
	logic         pslverr_ff;
	logic         irq_take_ff;
	logic         nmi_take_ff;

	logic [31:0]  dram [CIS_RAM_WORDS];
	logic [31:0]  iram [CIS_RAM_WORDS];

	logic         setup;
	logic         wr_ok;
	logic         cmd_go;
	cis_op_t      cmd_op;
	logic [3:0]   cmd_cond;
	logic         busy;
	logic         op_legal;
	logic         mapped;
	logic [3:0]   ram_base;
	logic [3:0]   rd_idx;
	logic [3:0]   wr_idx;
	logic [31:0]  and_rr;
	logic [31:0]  and_ri;
	logic [31:0]  imm5_sx;
	logic [31:0]  disp9_sx;
	logic [31:0]  disp16_sx;
	logic [31:0]  port_addr;
	logic [31:0]  divisor;
	logic [31:0]  q_s;
	logic [31:0]  r_s;
	logic [31:0]  q_u;
	logic [31:0]  r_u;
	logic         div_zero;
	logic         div_ovf;
	logic         fill_ack;
	logic         is_fill;
	logic         is_dump;
	logic         to_iram;

	// flags of a - b, shared by the compares and the exchange
	function automatic logic [3:0] sub_flags(input logic [31:0] a, input logic [31:0] b);
		logic [32:0] d;
		logic [3:0]  f;
		d = {1'b0, a} - {1'b0, b};
		f[CIS_F_CARRY]  = d[32];
		f[CIS_F_EXCESS] = (a[31] ^ b[31]) & (a[31] ^ d[31]);
		f[CIS_F_SIGN]   = d[31];
		f[CIS_F_ZERO]   = (d[31:0] == 32'h0000_0000);
		return f;
	endfunction : sub_flags

	// low three bits pick a test, top bit negates it
	function automatic logic cond_met(input logic [3:0] c, input logic [3:0] f);
		logic r;
		logic cf;
		logic vf;
		logic s;
		logic z;
		cf = f[CIS_F_CARRY];
		vf = f[CIS_F_EXCESS];
		s  = f[CIS_F_SIGN];
		z  = f[CIS_F_ZERO];
		case (c[2:0])
			3'h0: r = vf;
			3'h1: r = cf;
			3'h2: r = z;
			3'h3: r = cf | z;
			3'h4: r = s;
			3'h5: r = 1'b1;
			3'h6: r = s ^ vf;
			3'h7: r = (s ^ vf) | z;
			default: r = 1'b0;
		endcase
		return r ^ c[3];
	endfunction : cond_met

	assign setup     = psel & ~penable;
	assign wr_ok     = psel & penable & pready_ff & pwrite & ~pslverr_ff;
	assign cmd_op    = cis_op_t'(pwdata[CIS_OP_LSB +: 5]);
	assign cmd_cond  = pwdata[CIS_COND_LSB +: 4];
	assign cmd_go    = wr_ok & (paddr == CIS_A_CMD);
	assign busy      = (state_ff != CIS_IDLE);
	assign op_legal  = (pwdata[CIS_OP_LSB +: 5] <= CIS_PORT_IN_WORD);

	assign and_rr    = opa_ff & opb_ff;
	assign and_ri    = opa_ff & {16'h0000, imm_ff[15:0]};
	assign imm5_sx   = {{27{imm_ff[4]}}, imm_ff[4:0]};
	assign disp9_sx  = {{23{imm_ff[8]}}, imm_ff[8:1], 1'b0};
	assign disp16_sx = {{16{imm_ff[15]}}, imm_ff[15:0]};
	assign port_addr = opa_ff + disp16_sx;

	// divisor forced nonzero so the operator never sees zero
	assign div_zero  = (opa_ff == 32'h0000_0000);
	assign div_ovf   = (opb_ff == 32'h8000_0000) & (opa_ff == 32'hffff_ffff);
	assign divisor   = div_zero ? 32'h0000_0001 : opa_ff;
	assign q_s       = div_ovf ? 32'h8000_0000 : 32'($signed(opb_ff) / $signed(divisor));
	assign r_s       = div_ovf ? 32'h0000_0000 : 32'($signed(opb_ff) % $signed(divisor));
	assign q_u       = opb_ff / divisor;
	assign r_u       = opb_ff % divisor;

	assign is_fill   = (op_ff == CIS_DATA_RAM_BLOCK_FILL) | (op_ff == CIS_INSTR_RAM_BLOCK_FILL);
	assign is_dump   = (op_ff == CIS_DATA_RAM_BLOCK_DUMP) | (op_ff == CIS_INSTR_RAM_BLOCK_DUMP);
	assign to_iram   = (op_ff == CIS_INSTR_RAM_BLOCK_FILL) | (op_ff == CIS_INSTR_RAM_BLOCK_DUMP);
	assign ram_base  = opb_ff[5:2];
	assign wr_idx    = ram_base + {2'b00, beat_ff};
	// dump prefetches the next word, so the read index runs one ahead once busy
	assign rd_idx    = ram_base + {2'b00, beat_ff} + {3'b000, busy};
	assign fill_ack  = (state_ff == CIS_MEM) & mem_ack & is_fill;

	always_comb
	begin
		case (paddr)
			CIS_A_CMD, CIS_A_OPA, CIS_A_OPB, CIS_A_IMM, CIS_A_PC,
			CIS_A_FLAGS, CIS_A_REM, CIS_A_STAT, CIS_A_FEPC: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// apb answer: ready in the first access cycle, no wait states
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_ff  <= CIS_WORD_RST;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end
		else if (setup)
		begin
			pready_ff  <= 1'b1;
			pslverr_ff <= ~mapped | (pwrite & (busy | sleep_ff))
				| (pwrite & (paddr == CIS_A_CMD) & ~op_legal);
			case (paddr)
				CIS_A_OPA:   prdata_ff <= opa_ff;
				CIS_A_OPB:   prdata_ff <= opb_ff;
				CIS_A_IMM:   prdata_ff <= imm_ff;
				CIS_A_PC:    prdata_ff <= pc_ff;
				CIS_A_FLAGS: prdata_ff <= {28'h0, flags_ff};
				CIS_A_REM:   prdata_ff <= remainder_register_ff;
				CIS_A_STAT:  prdata_ff <= {28'h0, fatal_ff, sleep_ff, ie_ff, busy};
				CIS_A_FEPC:  prdata_ff <= fepc_ff;
				default:     prdata_ff <= CIS_WORD_RST;
			endcase
		end
		else
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end
	end

	// on-chip rams: no reset, contents undefined until filled
	always_ff @(posedge pclk)
	begin
		if (fill_ack & ~to_iram)
			dram[wr_idx] <= mem_rdata;
		if (fill_ack & to_iram)
			iram[wr_idx] <= mem_rdata;
	end

	// nmi passes ungated; only the maskable line sees the enable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_take_ff <= 1'b0;
			nmi_take_ff <= 1'b0;
		end
		else
		begin
			irq_take_ff <= int_req & ie_ff;
			nmi_take_ff <= nmi_req;
		end
	end

	// architectural state, sequencer and external request
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			opa_ff                <= CIS_WORD_RST;
			opb_ff                <= CIS_WORD_RST;
			imm_ff                <= CIS_WORD_RST;
			pc_ff                 <= CIS_WORD_RST;
			fepc_ff               <= CIS_WORD_RST;
			remainder_register_ff <= CIS_WORD_RST;
			flags_ff              <= CIS_FLAGS_RST;
			ie_ff                 <= CIS_IE_RST;
			sleep_ff              <= 1'b0;
			fatal_ff              <= 1'b0;
			state_ff              <= CIS_IDLE;
			op_ff                 <= CIS_REG_MASK_OP;
			beat_ff               <= 2'b00;
			mem_ff                <= '0;
		end
		else
		begin
			if (wr_ok)
			begin
				case (paddr)
					CIS_A_OPA:   opa_ff <= pwdata;
					CIS_A_OPB:   opb_ff <= pwdata;
					CIS_A_IMM:   imm_ff <= pwdata;
					CIS_A_PC:    pc_ff <= pwdata;
					CIS_A_FLAGS: flags_ff <= pwdata[3:0];
					CIS_A_REM:   remainder_register_ff <= pwdata;
					CIS_A_FEPC:  fepc_ff <= pwdata;
					CIS_A_STAT:
					begin
						ie_ff    <= pwdata[CIS_S_IE];
						fatal_ff <= pwdata[CIS_S_FATAL];
					end
					default: ;
				endcase
			end
			if (cmd_go)
			begin
				op_ff   <= cmd_op;
				beat_ff <= 2'b00;
				case (cmd_op)
					CIS_REG_MASK_OP:
					begin
						opb_ff                 <= and_rr;
						flags_ff[CIS_F_EXCESS] <= 1'b0;
						flags_ff[CIS_F_SIGN]   <= and_rr[31];
						flags_ff[CIS_F_ZERO]   <= (and_rr == 32'h0000_0000);
					end
					CIS_IMMEDIATE_MASK_OP:
					begin
						opb_ff                 <= and_ri;
						flags_ff[CIS_F_EXCESS] <= 1'b0;
						flags_ff[CIS_F_SIGN]   <= 1'b0;
						flags_ff[CIS_F_ZERO]   <= (and_ri == 32'h0000_0000);
					end
					CIS_COND_JUMP:
						if (cond_met(cmd_cond, flags_ff))
							pc_ff <= pc_ff + disp9_sx;
					CIS_ALWAYS_JUMP:
						pc_ff <= pc_ff + disp9_sx;
					CIS_DATA_RAM_BLOCK_FILL, CIS_INSTR_RAM_BLOCK_FILL:
					begin
						state_ff <= CIS_MEM;
						mem_ff   <= '{req: 1'b1, wr: 1'b0, io: 1'b0, size: CIS_SZ_WORD,
							addr: {opa_ff[31:2], 2'b00}, wdata: CIS_WORD_RST};
					end
					CIS_DATA_RAM_BLOCK_DUMP:
					begin
						state_ff <= CIS_MEM;
						mem_ff   <= '{req: 1'b1, wr: 1'b1, io: 1'b0, size: CIS_SZ_WORD,
							addr: {opa_ff[31:2], 2'b00}, wdata: dram[rd_idx]};
					end
					CIS_INSTR_RAM_BLOCK_DUMP:
					begin
						state_ff <= CIS_MEM;
						mem_ff   <= '{req: 1'b1, wr: 1'b1, io: 1'b0, size: CIS_SZ_WORD,
							addr: {opa_ff[31:2], 2'b00}, wdata: iram[rd_idx]};
					end
					CIS_FATAL_HANDLER_RETURN:
					begin
						pc_ff    <= fepc_ff;
						fatal_ff <= 1'b0;
					end
					CIS_INTERLOCK_EXCHANGE:
					begin
						state_ff <= CIS_MEM;
						mem_ff   <= '{req: 1'b1, wr: 1'b0, io: 1'b0, size: CIS_SZ_WORD,
							addr: {port_addr[31:2], 2'b00}, wdata: CIS_WORD_RST};
					end
					CIS_COMPARE_OP:
						flags_ff <= sub_flags(opb_ff, opa_ff);
					CIS_COMPARE_IMM_OP:
						flags_ff <= sub_flags(opb_ff, imm5_sx);
					CIS_MASK_IRQ_OFF:
						ie_ff <= 1'b0;
					CIS_MASK_IRQ_ON:
						ie_ff <= 1'b1;
					CIS_SIGNED_QUOTIENT_OP:
					begin
						// zero divisor leaves both registers alone and flags excess
						if (!div_zero)
						begin
							opb_ff                <= q_s;
							remainder_register_ff <= r_s;
							flags_ff[CIS_F_SIGN]  <= q_s[31];
							flags_ff[CIS_F_ZERO]  <= (q_s == 32'h0000_0000);
						end
						flags_ff[CIS_F_EXCESS] <= div_zero | div_ovf;
					end
					CIS_UNSIGNED_QUOTIENT_OP:
					begin
						if (!div_zero)
						begin
							opb_ff                <= q_u;
							remainder_register_ff <= r_u;
							flags_ff[CIS_F_SIGN]  <= q_u[31];
							flags_ff[CIS_F_ZERO]  <= (q_u == 32'h0000_0000);
						end
						flags_ff[CIS_F_EXCESS] <= 1'b0;
					end
					CIS_HALT_OP:
						sleep_ff <= 1'b1;
					CIS_PORT_IN_BYTE:
					begin
						state_ff <= CIS_MEM;
						mem_ff   <= '{req: 1'b1, wr: 1'b0, io: 1'b1, size: CIS_SZ_BYTE,
							addr: port_addr, wdata: CIS_WORD_RST};
					end
					CIS_PORT_IN_HALF:
					begin
						state_ff <= CIS_MEM;
						mem_ff   <= '{req: 1'b1, wr: 1'b0, io: 1'b1, size: CIS_SZ_HALF,
							addr: {port_addr[31:1], 1'b0}, wdata: CIS_WORD_RST};
					end
					CIS_PORT_IN_WORD:
					begin
						state_ff <= CIS_MEM;
						mem_ff   <= '{req: 1'b1, wr: 1'b0, io: 1'b1, size: CIS_SZ_WORD,
							addr: {port_addr[31:2], 2'b00}, wdata: CIS_WORD_RST};
					end
					default: ;
				endcase
			end
			case (state_ff)
				CIS_IDLE: ;
				CIS_MEM:
					if (mem_ack)
					begin
						if (is_fill | is_dump)
						begin
							beat_ff <= beat_ff + 2'b01;
							if (beat_ff == CIS_LAST_BEAT)
							begin
								state_ff   <= CIS_IDLE;
								mem_ff.req <= 1'b0;
								beat_ff    <= 2'b00;
							end
							else
							begin
								mem_ff.addr  <= mem_ff.addr + CIS_WORD_STEP;
								mem_ff.wdata <= to_iram ? iram[rd_idx] : dram[rd_idx];
							end
						end
						else if (op_ff == CIS_INTERLOCK_EXCHANGE)
						begin
							// swap in the remainder register only when memory matched reg2
							flags_ff     <= sub_flags(opb_ff, mem_rdata);
							opb_ff       <= mem_rdata;
							mem_ff.wr    <= 1'b1;
							mem_ff.wdata <= (opb_ff == mem_rdata) ?
								remainder_register_ff : mem_rdata;
							state_ff     <= CIS_XWR;
						end
						else
						begin
							state_ff   <= CIS_IDLE;
							mem_ff.req <= 1'b0;
							case (mem_ff.size)
								CIS_SZ_BYTE: opb_ff <= {24'h000000, mem_rdata[7:0]};
								CIS_SZ_HALF: opb_ff <= {16'h0000, mem_rdata[15:0]};
								default:     opb_ff <= mem_rdata;
							endcase
						end
					end
				CIS_XWR:
					if (mem_ack)
					begin
						state_ff   <= CIS_IDLE;
						mem_ff.req <= 1'b0;
						mem_ff.wr  <= 1'b0;
					end
				default: state_ff <= CIS_IDLE;
			endcase
			// wake wins over a halt issued in the same cycle only if already asleep
			if (sleep_ff & (nmi_req | (int_req & ie_ff)))
				sleep_ff <= 1'b0;
		end
	end

	assign prdata   = prdata_ff;
	assign pready   = pready_ff;
	assign pslverr  = pslverr_ff;
	assign mem_req  = mem_ff;
	assign irq_take = irq_take_ff;
	assign nmi_take = nmi_take_ff;
	assign sleeping = sleep_ff;

endmodule : cis_unit

// ===== cis_pkg.sv
// Purpose: shared constants and types for the instruction slice unit
// Assumes: 32-bit APB register access, byte addresses below
// Notes:   one word per register, reserved bits read as zero
package cis_pkg;

	localparam logic [7:0]  CIS_A_CMD     = 8'h00;
	localparam logic [7:0]  CIS_A_OPA     = 8'h04;
	localparam logic [7:0]  CIS_A_OPB     = 8'h08;
	localparam logic [7:0]  CIS_A_IMM     = 8'h0c;
	localparam logic [7:0]  CIS_A_PC      = 8'h10;
	localparam logic [7:0]  CIS_A_FLAGS   = 8'h14;
	localparam logic [7:0]  CIS_A_REM     = 8'h18;
	localparam logic [7:0]  CIS_A_STAT    = 8'h1c;
	localparam logic [7:0]  CIS_A_FEPC    = 8'h20;

	localparam int          CIS_OP_LSB    = 0;
	localparam int          CIS_COND_LSB  = 5;

	localparam int          CIS_F_CARRY   = 0;
	localparam int          CIS_F_EXCESS  = 1;
	localparam int          CIS_F_SIGN    = 2;
	localparam int          CIS_F_ZERO    = 3;

	localparam int          CIS_S_BUSY    = 0;
	localparam int          CIS_S_IE      = 1;
	localparam int          CIS_S_SLEEP   = 2;
	localparam int          CIS_S_FATAL   = 3;

	localparam logic [31:0] CIS_WORD_RST  = 32'h0000_0000;
	localparam logic [3:0]  CIS_FLAGS_RST = 4'h0;
	localparam logic        CIS_IE_RST    = 1'b0;

	localparam int          CIS_BLOCK_WORDS = 4;
	localparam logic [1:0]  CIS_LAST_BEAT   = 2'(CIS_BLOCK_WORDS - 1);
	localparam int          CIS_RAM_WORDS   = 16;
	localparam logic [31:0] CIS_WORD_STEP   = 32'h0000_0004;

	localparam logic [1:0]  CIS_SZ_BYTE   = 2'h0;
	localparam logic [1:0]  CIS_SZ_HALF   = 2'h1;
	localparam logic [1:0]  CIS_SZ_WORD   = 2'h2;

	typedef enum logic [4:0] {
		CIS_REG_MASK_OP          = 5'h00,
		CIS_IMMEDIATE_MASK_OP    = 5'h01,
		CIS_COND_JUMP            = 5'h02,
		CIS_ALWAYS_JUMP          = 5'h03,
		CIS_DATA_RAM_BLOCK_FILL  = 5'h04,
		CIS_DATA_RAM_BLOCK_DUMP  = 5'h05,
		CIS_INSTR_RAM_BLOCK_FILL = 5'h06,
		CIS_INSTR_RAM_BLOCK_DUMP = 5'h07,
		CIS_FATAL_HANDLER_RETURN = 5'h08,
		CIS_INTERLOCK_EXCHANGE   = 5'h09,
		CIS_COMPARE_OP           = 5'h0a,
		CIS_COMPARE_IMM_OP       = 5'h0b,
		CIS_MASK_IRQ_OFF         = 5'h0c,
		CIS_MASK_IRQ_ON          = 5'h0d,
		CIS_SIGNED_QUOTIENT_OP   = 5'h0e,
		CIS_UNSIGNED_QUOTIENT_OP = 5'h0f,
		CIS_HALT_OP              = 5'h10,
		CIS_PORT_IN_BYTE         = 5'h11,
		CIS_PORT_IN_HALF         = 5'h12,
		CIS_PORT_IN_WORD         = 5'h13
	} cis_op_t;

	typedef enum logic [1:0] {
		CIS_IDLE = 2'h0,
		CIS_MEM  = 2'h1,
		CIS_XWR  = 2'h2
	} cis_state_t;

	typedef struct packed {
		logic        req;
		logic        wr;
		logic        io;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} cis_mem_req_t;

endpackage : cis_pkg

// ===== cis_unit_asserts.sv
// Purpose: port-level checks for the instruction slice unit
// Assumes: one clock domain, presetn asynchronous active low
// Notes:   beat counter bounds block transfers at four words
`timescale 1ns/100ps
module cis_unit_asserts
	import cis_pkg::*;
(
	input logic                  pclk,
	input logic                  presetn,
	input logic                  psel,
	input logic                  penable,
	input logic                  pwrite,
	input logic [7:0]            paddr,
	input logic [31:0]           pwdata,
	input logic [31:0]           prdata,
	input logic                  pready,
	input logic                  pslverr,
	input cis_pkg::cis_mem_req_t mem_req,
	input logic                  mem_ack,
	input logic [31:0]           mem_rdata,
	input logic                  int_req,
	input logic                  nmi_req,
	input logic                  irq_take,
	input logic                  nmi_take,
	input logic                  sleeping
);
	logic [2:0] beat_ff;
	logic [2:0] nxt_beat;

	// counts acks while the request stays up, cleared when it drops
	always_comb
	begin
		nxt_beat = beat_ff;
		if (!mem_req.req)
			nxt_beat = 3'h0;
		else if (mem_ack)
			nxt_beat = beat_ff + 3'h1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			beat_ff <= 3'h0;
		else
			beat_ff <= nxt_beat;
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	req_hold_a: assert property (mem_req.req && !mem_ack |=> mem_req.req
		&& $stable(mem_req.addr) && $stable(mem_req.wr) && $stable(mem_req.wdata))
		else $error("memory request changed before ack");
	beat_step_a: assert property (mem_req.req && mem_ack ##1 (mem_req.req
		&& !mem_req.io && mem_req.wr == $past(mem_req.wr))
		|-> mem_req.addr == $past(mem_req.addr) + 32'h4)
		else $error("block beat address not one word on");
	beat_max_a: assert property (beat_ff <= 3'h4)
		else $error("more than four beats in one request run");
	half_align_a: assert property (mem_req.req && mem_req.io
		&& mem_req.size == CIS_SZ_HALF |-> !mem_req.addr[0])
		else $error("halfword port address odd");
	word_align_a: assert property (mem_req.req && mem_req.io
		&& mem_req.size == CIS_SZ_WORD |-> mem_req.addr[1:0] == 2'h0)
		else $error("word port address not aligned");
	port_read_a: assert property (mem_req.req && mem_req.io |-> !mem_req.wr)
		else $error("port access is not a read");
	nmi_pass_a: assert property (1'b1 |=> nmi_take == $past(nmi_req))
		else $error("nmi not passed one cycle late");
	irq_cause_a: assert property (irq_take |-> $past(int_req))
		else $error("irq taken without request");
	sleep_quiet_a: assert property (sleeping |-> !mem_req.req)
		else $error("memory traffic while asleep");
	nmi_wake_a: assert property (sleeping && nmi_req |-> ##[1:2] !sleeping)
		else $error("nmi did not end sleep");
endmodule : cis_unit_asserts

bind cis_unit cis_unit_asserts i_cis_unit_asserts (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
	.mem_ack(mem_ack), .mem_rdata(mem_rdata), .int_req(int_req), .nmi_req(nmi_req),
	.irq_take(irq_take), .nmi_take(nmi_take), .sleeping(sleeping));

// ===== testbench.sv
// Purpose: self-checking bench for the instruction slice unit
// Assumes: zero-wait apb slave, memory acks paced every other cycle
// Notes:   external memory is a 64-word array, ports return a pattern
`timescale 1ns/100ps
module testbench;
	import cis_pkg::*;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, mem_rdata, q, pa, x0;
	cis_mem_req_t mem_req;
	logic         mem_ack, int_req, nmi_req, irq_take, nmi_take, sleeping, stl_ff, e;
	logic [31:0]  ext [64];
	int           mismatches, compares;

	cis_unit i_cis_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.int_req(int_req), .nmi_req(nmi_req), .irq_take(irq_take), .nmi_take(nmi_take),
		.sleeping(sleeping));

	function automatic logic [31:0] pv(input logic [31:0] a);
		return 32'h8765_4321 ^ a;
	endfunction : pv

	function automatic logic taken(input logic [3:0] f, input logic [3:0] c);
		logic [7:0] t;
		t = {(f[2] ^ f[1]) | f[3], f[2] ^ f[1], 1'b1, f[2], f[0] | f[3], f[3], f[0], f[1]};
		return t[c[2:0]] ^ c[3];
	endfunction : taken

	// slow memory; idle data inverted so a stale word never looks valid
	always @(posedge pclk)
	begin
		stl_ff <= ~stl_ff;
		mem_ack <= mem_req.req && !mem_ack && stl_ff;
		mem_rdata <= (mem_req.req && !mem_ack && stl_ff) ?
			(mem_req.io ? pv(mem_req.addr) : ext[mem_req.addr[7:2]]) : ~mem_rdata;
		if (mem_ack && mem_req.req && mem_req.wr)
			ext[mem_req.addr[7:2]] <= mem_req.wdata;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, x);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x);
	endtask : rc

	// polls busy so the next write is never refused
	task automatic cmd(input logic [4:0] op, input logic [3:0] c);
		apb(1'b1, CIS_A_CMD, {23'h0, c, op});
		do
			apb(1'b0, CIS_A_STAT, 32'h0);
		while (q[0] !== 1'b0);
	endtask : cmd

	task automatic dv(input logic [4:0] op, input logic [31:0] b, input logic [31:0] a,
		input logic [31:0] qx, input logic [31:0] rx, input logic [3:0] fx);
		wr(CIS_A_FLAGS, 32'h1);
		wr(CIS_A_OPA, a);
		wr(CIS_A_OPB, b);
		cmd(op, 4'h0);
		rc(CIS_A_OPB, qx);
		rc(CIS_A_REM, rx);
		rc(CIS_A_FLAGS, {28'h0, fx});
	endtask : dv

	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// whole run needs well under half of this
	initial
	begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		stop_test();
	end

	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{mem_ack, mem_rdata, int_req, nmi_req, stl_ff} = '0;
		for (int i = 0; i < 64; i++)
			ext[i] = {16'h5a3c, 8'(i), ~8'(i)};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		wr(CIS_A_FLAGS, 32'h3);
		wr(CIS_A_OPA, 32'hf0f0_00ff);
		wr(CIS_A_OPB, 32'h8f00_f0f1);
		cmd(5'h00, 4'h0);
		rc(CIS_A_OPB, 32'h8000_00f1);
		rc(CIS_A_FLAGS, 32'h5);
		wr(CIS_A_FLAGS, 32'hf);
		wr(CIS_A_OPA, 32'hffff_ffff);
		wr(CIS_A_IMM, 32'h0000_8001);
		cmd(5'h01, 4'h0);
		rc(CIS_A_OPB, 32'h0000_8001);
		rc(CIS_A_FLAGS, 32'h1);
		$display("test and done");
		wr(CIS_A_FLAGS, 32'h0);
		wr(CIS_A_OPA, 32'h5);
		wr(CIS_A_OPB, 32'h3);
		cmd(5'h0a, 4'h0);
		rc(CIS_A_OPB, 32'h3);
		rc(CIS_A_FLAGS, 32'h5);
		wr(CIS_A_IMM, 32'h1f);
		wr(CIS_A_OPB, 32'hffff_ffff);
		cmd(5'h0b, 4'h0);
		rc(CIS_A_FLAGS, 32'h8);
		$display("test compare done");
		wr(CIS_A_IMM, 32'h1ff);
		for (int f = 0; f < 16; f++)
			for (int c = 0; c < 16; c++)
			begin
				wr(CIS_A_FLAGS, 32'(f));
				wr(CIS_A_PC, 32'h100);
				cmd(5'h02, 4'(c));
				rc(CIS_A_PC, taken(4'(f), 4'(c)) ? 32'hfe : 32'h100);
				rc(CIS_A_FLAGS, 32'(f));
			end
		wr(CIS_A_IMM, 32'h0ff);
		wr(CIS_A_FLAGS, 32'ha);
		wr(CIS_A_PC, 32'h100);
		cmd(5'h03, 4'h0);
		rc(CIS_A_PC, 32'h1fe);
		rc(CIS_A_FLAGS, 32'ha);
		$display("test jump done");
		// both fills before both dumps, so a shared ram would show
		wr(CIS_A_OPA, 32'h23);
		wr(CIS_A_OPB, 32'h08);
		cmd(5'h04, 4'h0);
		wr(CIS_A_OPA, 32'h40);
		wr(CIS_A_OPB, 32'h3c);
		cmd(5'h06, 4'h0);
		wr(CIS_A_OPA, 32'hc0);
		cmd(5'h07, 4'h0);
		wr(CIS_A_OPA, 32'h80);
		wr(CIS_A_OPB, 32'h08);
		cmd(5'h05, 4'h0);
		for (int i = 0; i < 4; i++)
		begin
			chk(ext[32 + i], ext[8 + i]);
			chk(ext[48 + i], ext[16 + i]);
		end
		$display("test block done");
		wr(CIS_A_IMM, 32'h0000_fff3);
		for (int k = 0; k < 3; k++)
		begin
			cmd(5'(5'h11 + k), 4'h0);
			pa = 32'h73 & ~((32'h1 << k) - 32'h1);
			rc(CIS_A_OPB, pv(pa) & 32'((64'h1 << (8 << k)) - 64'h1));
		end
		x0 = ext[4];
		wr(CIS_A_OPA, 32'h10);
		wr(CIS_A_IMM, 32'h0);
		wr(CIS_A_OPB, x0);
		wr(CIS_A_REM, 32'h1234_5678);
		wr(CIS_A_FLAGS, 32'h1);
		cmd(5'h09, 4'h0);
		rc(CIS_A_OPB, x0);
		rc(CIS_A_FLAGS, 32'h8);
		chk(ext[4], 32'h1234_5678);
		$display("test port done");
		dv(5'h0e, 32'hffff_fff9, 32'h2, 32'hffff_fffd, 32'hffff_ffff, 4'h5);
		dv(5'h0e, 32'h7, 32'hffff_fffe, 32'hffff_fffd, 32'h1, 4'h5);
		dv(5'h0e, 32'h8000_0000, 32'hffff_ffff, 32'h8000_0000, 32'h0, 4'h7);
		dv(5'h0f, 32'hffff_fff9, 32'h2, 32'h7fff_fffc, 32'h1, 4'h1);
		dv(5'h0f, 32'h6, 32'h7, 32'h0, 32'h6, 4'h9);
		dv(5'h0e, 32'h9, 32'h0, 32'h9, 32'h6, 4'h3);
		dv(5'h0f, 32'h9, 32'h0, 32'h9, 32'h6, 4'h1);
		$display("test divide done");
		wr(CIS_A_STAT, 32'h2);
		int_req <= 1'b1;
		cmd(5'h0c, 4'h0);
		chk(irq_take, 32'h0);
		nmi_req <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(nmi_take, 32'h1);
		nmi_req <= 1'b0;
		cmd(5'h0d, 4'h0);
		chk(irq_take, 32'h1);
		rc(CIS_A_STAT, 32'h2);
		int_req <= 1'b0;
		apb(1'b1, CIS_A_CMD, 32'h10);
		apb(1'b0, CIS_A_STAT, 32'h0);
		chk(q[2], 32'h1);
		chk(sleeping, 32'h1);
		apb(1'b1, CIS_A_CMD, 32'h0d);
		chk(e, 32'h1);
		nmi_req <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(sleeping, 32'h0);
		nmi_req <= 1'b0;
		$display("test irq done");
		wr(CIS_A_FEPC, 32'habc);
		wr(CIS_A_STAT, 32'ha);
		wr(CIS_A_FLAGS, 32'h6);
		cmd(5'h08, 4'h0);
		rc(CIS_A_PC, 32'habc);
		rc(CIS_A_STAT, 32'h2);
		rc(CIS_A_FLAGS, 32'h6);
		apb(1'b1, 8'h24, 32'h0);
		chk(e, 32'h1);
		apb(1'b1, CIS_A_CMD, 32'h14);
		chk(e, 32'h1);
		$display("test fatal done");
		stop_test();
	end
endmodule : testbench
